// *** dv/srctl_ctl_model.sv ***
// Memory controller stand-in that drives the command pins of the device
module srctl_ctl_model (
    // Clock
    input  wire logic                  sys_clk,
    // Command pins toward the device
    output srctl_pkg::srctl_cmd_t      cmd_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    import srctl_pkg::*;

    localparam srctl_cmd_t DES_HI = 6'h3f;  // Deselect, clock enable high
    localparam srctl_cmd_t DES_LO = 6'h3e;  // Deselect, clock enable low
    localparam srctl_cmd_t SR_ENT = 6'h12;  // Chip select, row and column strobes low with clock enable low
    localparam srctl_cmd_t REF_CMD  = 6'h13;  // Refresh: same strobes low, clock enable high
    localparam int         REF_WAIT = 66;     // Refresh cycle time in clocks plus one

    // Start parked on deselect with the device idle
    initial cmd_pins = DES_HI;

    // Every change lands just after a rising edge and holds for n edges
    task automatic drive(input srctl_cmd_t c, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            cmd_pins <= c;
        end
    endtask

    // Bench only calls this with the device idle and prior timings met
    // The extra refresh also covers re-entry right after an exit; entry waits out its cycle time
    task automatic enter();
        drive(REF_CMD, 1);
        drive(DES_HI, REF_WAIT);
        drive(SR_ENT, 1);
        drive(DES_LO, 2);
    endtask

    // Residency with junk on the control pins, which the device must ignore
    task automatic hold(input int n);
        for (int i = 0; i < n; i++) begin
            drive({i[4:0] ^ 5'h15, 1'b0}, 1);
        end
        drive(DES_LO, 4);
    endtask

    // Clock enable pulse while selected: not a valid exit
    task automatic bad_exit();
        drive(6'h13, 4);
        drive(DES_LO, 4);
    endtask

    // Deselect stays on the bus and clock enable stays high until the next call
    task automatic leave();
        drive(DES_HI, 1);
    endtask
endmodule // srctl_ctl_model

// *** dv/srctl_top_bench.sv ***
module srctl_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import srctl_pkg::*;

    localparam int TXS_N   = (260 + 10 + 3) / 4;  // Refresh cycle plus 10 ns in 4 ns cycles
    localparam int ABORT_N = 30;
    localparam int DLL_N   = 100;  // Shortened so runs stay brief
    localparam int FIRST_N = 2;
    localparam int REF_N   = 40;

    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    srctl_cmd_t  cmd_pins;
    logic        reset_pin_n = 1'b1;
    logic        temp_hot = 1'b0;
    logic        sr_active, term_hiz, dll_enable, dll_reset, int_clk_en, vref_ready;
    logic        fast_exit_ok, dll_exit_ok, refresh_pulse;
    logic [2:0]  term_park;
    logic [1:0]  refresh_rate, s_axi_bresp, s_axi_rresp;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int          err_count = 0, compares = 0, cyc = 0, n_ref = 0, t0 = 0, t1 = 0, t2 = 0, w = 0;
    logic        sr_prev = 1'b0;
    logic [31:0] rd;
    logic [1:0]  rr;

    always #2 sys_clk = ~sys_clk;

    srctl_top #(.TXS_CYC(TXS_N), .LOCKED_DLL_EXIT_DELAY_CYC(DLL_N), .REF_INT_CYC(REF_N)) i_srctl_top (
        .sys_clk, .sys_rst, .cmd_pins, .reset_pin_n, .temp_hot, .sr_active, .term_hiz, .term_park,
        .dll_enable, .dll_reset, .int_clk_en, .vref_ready, .fast_exit_ok, .dll_exit_ok, .refresh_pulse,
        .refresh_rate, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    srctl_ctl_model i_srctl_ctl_model (
        .sys_clk  (sys_clk),
        .cmd_pins (cmd_pins)
    );

    // Stamp the first two internal refreshes of each residency
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        sr_prev <= sr_active;
        if (sr_active === 1'b1 && sr_prev !== 1'b1) t0 <= cyc;
        if (sr_active !== 1'b1) n_ref <= 0;
        else if (refresh_pulse === 1'b1) begin
            n_ref <= n_ref + 1;
            if (n_ref == 0) t1 <= cyc;
            if (n_ref == 1) t2 <= cyc;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Both write channels offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int t;
        t = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            t++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && t < 50);
        r = s_axi_bresp;
        if (s_axi_bvalid !== 1'b1) err_count++;
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int t;
        t = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            t++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && t < 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (s_axi_rvalid !== 1'b1) err_count++;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Bounded wait on a level; a limit that runs out shows in a later compare, except in the reset pin test
    task automatic wait_hi(ref logic s, input int lim, output int n);
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    // One full residency: program, enter, reject a false exit and then junk, leave, time the exit
    task automatic sr_round(input logic [8:0] ctrl, input logic [1:0] rate, input int xs);
        int n;
        int m;
        logic [31:0] c0;
        axi_wr(8'h00, {23'h0, ctrl}, rr);
        i_srctl_ctl_model.enter();
        wait_hi(sr_active, 20, n);
        check("sr_active", sr_active, 1'b1);
        check("term_hiz", term_hiz, 1'b1);
        check("dll_enable", dll_enable, 1'b0);
        check("int_clk_en", int_clk_en, 1'b0);
        check("refresh_rate", refresh_rate, rate);
        i_srctl_ctl_model.bad_exit();
        i_srctl_ctl_model.hold(200);
        check("sr_stays", sr_active, 1'b1);
        check("first_refresh", t1 > t0 && t1 - t0 <= FIRST_N + 1, 1'b1);
        check("refresh_gap", t2 - t1, rate == 2'b01 ? REF_N / 2 : rate == 2'b10 ? REF_N * 2 : REF_N);
        axi_rd(8'h08, c0, rr);
        i_srctl_ctl_model.leave();
        wait_hi(int_clk_en, 20, n);
        check("int_clk_exit", int_clk_en, 1'b1);
        check("dll_reset", dll_reset, ctrl[7]);
        check("term_park", term_park, ctrl[3] ? ctrl[2:0] : 3'h0);
        check("term_hiz_exit", term_hiz, 1'b0);
        check("fast_early", fast_exit_ok, 1'b0);
        wait_hi(fast_exit_ok, 1000, n);
        check("vref_ready", vref_ready, 1'b1);
        check("fast_exit_span", n + 1 >= xs && n <= xs + 1, 1'b1);
        check("dll_early", dll_exit_ok, 1'b0);
        wait_hi(dll_exit_ok, 1000, m);
        check("dll_exit_span", n + m + 1 >= DLL_N && n + m <= DLL_N + 1, 1'b1);
        check("dll_relocked", dll_enable, ctrl[7]);
        check("sr_left", sr_active, 1'b0);
        // Reduced rate leaves gaps between refreshes, so whether one is in flight at exit is not fixed
        axi_rd(8'h08, rd, rr);
        if (rate != 2'b10) check("refresh_count", rd - c0, ctrl[4] ? 32'h0 : 32'h1);
        repeat (4) @(posedge sys_clk);
        $display("Residency test with control %h done", ctrl);
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        check("idle_flags", {sr_active, term_hiz, dll_enable, int_clk_en, fast_exit_ok, dll_exit_ok}, 6'h07);
        axi_rd(8'h00, rd, rr);
        check("ctrl_reset", rd, 32'h0000_0080);
        axi_rd(8'h04, rd, rr);
        check("stat_reset", rd, 32'h0000_01c0);
        axi_wr(8'h04, 32'hffff_ffff, rr);
        check("ro_write_resp", rr, 2'h0);
        axi_rd(8'h0c, rd, rr);
        check("unmapped_resp", rr, 2'h2);
        $display("Register test done");
        sr_round(9'h18d, 2'b00, TXS_N);
        temp_hot <= 1'b1;
        // Auto mode runs hot here, so it must pick the extended rate; round two runs with the DLL off
        for (int k = 1; k < 4; k++) begin
            sr_round({1'b0, k != 2, k[1:0], k[0], 4'h3}, k == 3 ? 2'b01 : k[1:0], k[0] ? ABORT_N : TXS_N);
        end
        i_srctl_ctl_model.enter();
        wait_hi(sr_active, 20, w);
        reset_pin_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        check("reset_pin", sr_active, 1'b0);
        reset_pin_n <= 1'b1;
        i_srctl_ctl_model.leave();
        $display("Reset pin test done");
        complete_run();
    end
endmodule // srctl_top_bench

// *** hw/srctl_cfg.svh ***
`ifndef SRCTL_CFG_SVH
`define SRCTL_CFG_SVH

// Register byte offsets
`define SRCTL_CTRL_OFS       8'h00
`define SRCTL_STAT_OFS       8'h04
`define SRCTL_RCNT_OFS       8'h08

// Control register fields
`define SRCTL_PARK_LSB       0
`define SRCTL_PARK_EN_BIT    3
`define SRCTL_ABORT_BIT      4
`define SRCTL_MODE_LSB       5
`define SRCTL_DLL_ON_BIT     7
`define SRCTL_VREF_OFF_BIT   8
`define SRCTL_CTRL_RST       9'h080

// Bus responses
`define SRCTL_RESP_OK        2'h0
`define SRCTL_RESP_SLVERR    2'h2

// Timing in ns and cycles at the 4 ns system clock
`define SRCTL_CLK_NS         4
`define SRCTL_TRFC_NS        260
`define SRCTL_TXS_EXTRA_NS   10
`define SRCTL_TXS_CYC        ((`SRCTL_TRFC_NS + `SRCTL_TXS_EXTRA_NS + `SRCTL_CLK_NS - 1) / `SRCTL_CLK_NS)
`define SRCTL_TRFC_CYC       ((`SRCTL_TRFC_NS + `SRCTL_CLK_NS - 1) / `SRCTL_CLK_NS)
`define SRCTL_TXS_ABORT_CYC  30
`define SRCTL_LOCKED_DLL_EXIT_DELAY_CYC     768
`define SRCTL_FIRST_REF_CYC  2
`define SRCTL_REF_INT_CYC    1950

`endif

// *** hw/srctl_pkg.sv ***
package srctl_pkg;
    // Residency states of the device
    typedef enum logic [1:0] {
        SRCTL_IDLE = 2'b00,
        SRCTL_SR   = 2'b01,
        SRCTL_EXIT = 2'b10
    } srctl_state_t;

    // Command/address control pins, all active low except clock enable
    typedef struct packed {
        logic cs_n;
        logic act_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
    } srctl_cmd_t;

    // Software control fields
    typedef struct packed {
        logic       vref_off;
        logic       dll_on;
        logic [1:0] low_power_self_refresh_select;
        logic       abort_en;
        logic       park_en;
        logic [2:0] parked_termination_value;
    } srctl_ctrl_t;
endpackage

// *** hw/srctl_top.sv ***
// Function
// - Decode entry: CS RAS CAS CKE low, WE ACT high
// - Entry forces termination off, high impedance
// - Exit restores parked termination when enabled
// - DLL off at entry, reset and on at exit when DLL bit set
// - In residency ignore all but CKE, CS, RESET
// - Data reference stable within exit delay
// - Internal refresh within CKE pulse period
// - Exit on CKE rising with deselect
// - Exit delay equals refresh cycle plus 10ns
// - Abort bit cancels refresh, shortens exit delay
// - Two-bit mode selects self-refresh rate
`include "srctl_cfg.svh"

module srctl_top #(
    parameter int unsigned TXS_CYC       = `SRCTL_TXS_CYC,
    parameter int unsigned TXS_ABORT_CYC = `SRCTL_TXS_ABORT_CYC,
    parameter int unsigned LOCKED_DLL_EXIT_DELAY_CYC    = `SRCTL_LOCKED_DLL_EXIT_DELAY_CYC,
    parameter int unsigned TRFC_CYC      = `SRCTL_TRFC_CYC,
    parameter int unsigned FIRST_REF_CYC = `SRCTL_FIRST_REF_CYC,
    parameter int unsigned REF_INT_CYC   = `SRCTL_REF_INT_CYC
) (
    // Clock and reset
    input  wire  logic                 sys_clk,
    input  wire  logic                 sys_rst,
    // Device pins, asynchronous to sys_clk
    input  wire  srctl_pkg::srctl_cmd_t cmd_pins,
    input  wire  logic                 reset_pin_n,
    input  wire  logic                 temp_hot,
    // Device internal controls
    output logic                       sr_active,
    output logic                       term_hiz,
    output logic [2:0]                 term_park,
    output logic                       dll_enable,
    output logic                       dll_reset,
    output logic                       int_clk_en,
    output logic                       vref_ready,
    output logic                       fast_exit_ok,
    output logic                       dll_exit_ok,
    output logic                       refresh_pulse,
    output logic [1:0]                 refresh_rate,
    // AXI4-Lite slave
    input  wire  logic [7:0]           s_axi_awaddr,
    input  wire  logic                 s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire  logic [31:0]          s_axi_wdata,
    input  wire  logic [3:0]           s_axi_wstrb,
    input  wire  logic                 s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire  logic                 s_axi_bready,
    input  wire  logic [7:0]           s_axi_araddr,
    input  wire  logic                 s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire  logic                 s_axi_rready
);
    import srctl_pkg::*;

    // Two-stage synchronisers on every pin; stage one feeds only stage two
    srctl_cmd_t   cmd_m_q, cmd_s_q;
    logic [1:0]   pin_m_q, pin_s_q;
    logic         cke_prev_q;
    always_ff @(posedge sys_clk) begin
        cmd_m_q    <= cmd_pins;
        cmd_s_q    <= cmd_m_q;
        pin_m_q    <= {reset_pin_n, temp_hot};
        pin_s_q    <= pin_m_q;
        cke_prev_q <= cmd_s_q.cke;
    end

    // Command decode
    logic sre_cmd, srx_cmd, pin_rst;
    assign sre_cmd = ~cmd_s_q.cs_n & ~cmd_s_q.ras_n & ~cmd_s_q.cas_n & ~cmd_s_q.cke
                     & cmd_s_q.we_n & cmd_s_q.act_n;
    assign srx_cmd = cmd_s_q.cke & ~cke_prev_q & cmd_s_q.cs_n;
    assign pin_rst = ~pin_s_q[1];

    // Core state
    srctl_ctrl_t  ctrl_q, ctrl_d;
    srctl_state_t st_q, st_d;
    logic [15:0]  tmr_q, tmr_d, xcnt_q, xcnt_d, rbusy_q, rbusy_d, rcnt_q, rcnt_d;
    logic         hiz_q, hiz_d, dll_q, dll_d, dllr_q, dllr_d, clk_q, clk_d;
    logic         vref_q, vref_d, fx_q, fx_d, dx_q, dx_d, rp_q, rp_d, abort_q, abort_d;
    logic [2:0]   park_q, park_d;
    logic [1:0]   rate_q, rate_d;
    logic [15:0]  xs_lim, rint;

    // Exit delay follows the abort option; the refresh period follows the mode
    always_comb begin
        xs_lim = ctrl_q.abort_en ? 16'(TXS_ABORT_CYC) : 16'(TXS_CYC);
        unique case (rate_q)
            2'b01:   rint = 16'(REF_INT_CYC / 2);
            2'b10:   rint = 16'(REF_INT_CYC * 2);
            default: rint = 16'(REF_INT_CYC);
        endcase
    end

    // Next-state logic of entry, residency and exit
    always_comb begin
        st_d = st_q; tmr_d = tmr_q; xcnt_d = xcnt_q; rbusy_d = rbusy_q; rcnt_d = rcnt_q;
        hiz_d = hiz_q; dll_d = dll_q; dllr_d = 1'b0; clk_d = clk_q; vref_d = vref_q;
        fx_d = fx_q; dx_d = dx_q; rp_d = 1'b0; park_d = park_q; rate_d = rate_q;
        abort_d = 1'b0;
        // Mode is sampled at entry; auto mode tracks temperature
        if (ctrl_q.low_power_self_refresh_select == 2'b11) begin
            rate_d = pin_s_q[0] ? 2'b01 : 2'b00;
        end else if (st_q != SRCTL_SR) begin
            rate_d = ctrl_q.low_power_self_refresh_select;
        end
        // Refresh in flight counts down and then advances the row counter
        if (rbusy_q != 16'h0000) begin
            rbusy_d = rbusy_q - 16'h0001;
            if (rbusy_q == 16'h0001) begin
                rcnt_d = rcnt_q + 16'h0001;
            end
        end
        unique case (st_q)
            SRCTL_IDLE: begin
                if (sre_cmd) begin
                    st_d   = SRCTL_SR;
                    hiz_d  = 1'b1;
                    dll_d  = 1'b0;
                    clk_d  = 1'b0;
                    tmr_d  = 16'(FIRST_REF_CYC);
                    fx_d   = 1'b0;
                    dx_d   = 1'b0;
                    vref_d = ~ctrl_q.vref_off;
                end
            end
            SRCTL_SR: begin
                // Built-in timer: first refresh early, then at the mode rate
                if (tmr_q <= 16'h0001) begin
                    rp_d    = 1'b1;
                    rbusy_d = 16'(TRFC_CYC);
                    tmr_d   = rint;
                end else begin
                    tmr_d = tmr_q - 16'h0001;
                end
                // Only clock enable and chip select are looked at here
                if (srx_cmd) begin
                    st_d   = SRCTL_EXIT;
                    xcnt_d = 16'h0000;
                    clk_d  = 1'b1;
                    dllr_d = ctrl_q.dll_on;
                    dll_d  = ctrl_q.dll_on;
                    hiz_d  = 1'b0;
                    park_d = ctrl_q.park_en ? ctrl_q.parked_termination_value : 3'h0;
                    if (ctrl_q.abort_en && rbusy_q != 16'h0000) begin
                        rbusy_d = 16'h0000;
                        rcnt_d  = rcnt_q; // cut refresh is never counted
                        abort_d = 1'b1;
                    end
                end
            end
            SRCTL_EXIT: begin
                xcnt_d = xcnt_q + 16'h0001;
                if (xcnt_d == xs_lim) begin
                    fx_d   = 1'b1;
                    vref_d = 1'b1;
                end
                if (xcnt_d == 16'(LOCKED_DLL_EXIT_DELAY_CYC)) begin
                    dx_d = 1'b1;
                    st_d = SRCTL_IDLE;
                end
                // Re-entry is legal once the fast exit delay has run
                if (fx_q && sre_cmd) begin
                    st_d  = SRCTL_SR;
                    hiz_d = 1'b1;
                    dll_d = 1'b0;
                    clk_d = 1'b0;
                    tmr_d = 16'(FIRST_REF_CYC);
                    fx_d  = 1'b0;
                    dx_d  = 1'b0;
                    vref_d = ~ctrl_q.vref_off;
                end
            end
            default: st_d = SRCTL_IDLE;
        endcase
        // Reset pin overrides state, termination, DLL, internal clock and any refresh in flight
        if (pin_rst) begin
            st_d = SRCTL_IDLE; hiz_d = 1'b0; dll_d = 1'b0; clk_d = 1'b1; rbusy_d = 16'h0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= SRCTL_IDLE; tmr_q <= 16'h0000; xcnt_q <= 16'h0000; rbusy_q <= 16'h0000;
            rcnt_q <= 16'h0000; hiz_q <= 1'b0; dll_q <= 1'b0; dllr_q <= 1'b0; clk_q <= 1'b1;
            vref_q <= 1'b1; fx_q <= 1'b1; dx_q <= 1'b1; rp_q <= 1'b0; park_q <= 3'h0;
            rate_q <= 2'b00; abort_q <= 1'b0;
        end else begin
            st_q <= st_d; tmr_q <= tmr_d; xcnt_q <= xcnt_d; rbusy_q <= rbusy_d;
            rcnt_q <= rcnt_d; hiz_q <= hiz_d; dll_q <= dll_d; dllr_q <= dllr_d; clk_q <= clk_d;
            vref_q <= vref_d; fx_q <= fx_d; dx_q <= dx_d; rp_q <= rp_d; park_q <= park_d;
            rate_q <= rate_d; abort_q <= abort_d;
        end
    end

    assign sr_active = (st_q == SRCTL_SR);
    assign term_hiz = hiz_q; assign term_park = park_q; assign dll_enable = dll_q;
    assign dll_reset = dllr_q; assign int_clk_en = clk_q; assign vref_ready = vref_q;
    assign fast_exit_ok = fx_q; assign dll_exit_ok = dx_q; assign refresh_pulse = rp_q;
    assign refresh_rate = rate_q;

    // AXI4-Lite slave; address and data may arrive in either order
    logic        awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0]  ws_q, ws_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    always_comb begin
        awh_d = awh_q; wh_d = wh_q; bv_d = bv_q; rv_d = rv_q; awa_d = awa_q; wd_d = wd_q;
        ws_d = ws_q; br_d = br_q; rr_d = rr_q; rd_d = rd_q; ctrl_d = ctrl_q;
        if (s_axi_awvalid && !awh_q && !bv_q) begin
            awh_d = 1'b1; awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wh_q && !bv_q) begin
            wh_d = 1'b1; wd_d = s_axi_wdata; ws_d = s_axi_wstrb;
        end
        if (awh_q && wh_q) begin
            awh_d = 1'b0; wh_d = 1'b0; bv_d = 1'b1;
            br_d  = `SRCTL_RESP_OK;
            if (awa_q[7:2] == 6'(`SRCTL_CTRL_OFS >> 2)) begin
                if (ws_q[0]) ctrl_d[7:0] = wd_q[7:0];
                if (ws_q[1]) ctrl_d[8] = wd_q[8];
            end else if (awa_q[7:2] != 6'(`SRCTL_STAT_OFS >> 2) && awa_q[7:2] != 6'(`SRCTL_RCNT_OFS >> 2)) begin
                br_d = `SRCTL_RESP_SLVERR;
            end
        end
        if (bv_q && s_axi_bready) bv_d = 1'b0;
        if (rv_q && s_axi_rready) rv_d = 1'b0;
        if (s_axi_arvalid && !rv_q) begin
            rv_d = 1'b1; rr_d = `SRCTL_RESP_OK; rd_d = 32'h0;
            unique case (s_axi_araddr[7:2])
                6'(`SRCTL_CTRL_OFS >> 2): rd_d = {23'h0, ctrl_q};
                6'(`SRCTL_STAT_OFS >> 2): rd_d = {22'h0, abort_q, vref_q, dx_q, fx_q, dll_q, hiz_q, rate_q, st_q};
                6'(`SRCTL_RCNT_OFS >> 2): rd_d = {16'h0, rcnt_q};
                default:                  rr_d = `SRCTL_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            awh_q <= 1'b0; wh_q <= 1'b0; bv_q <= 1'b0; rv_q <= 1'b0; awa_q <= 8'h00;
            wd_q <= 32'h0; ws_q <= 4'h0; br_q <= 2'h0; rr_q <= 2'h0; rd_q <= 32'h0;
            ctrl_q <= `SRCTL_CTRL_RST;
        end else begin
            awh_q <= awh_d; wh_q <= wh_d; bv_q <= bv_d; rv_q <= rv_d; awa_q <= awa_d;
            wd_q <= wd_d; ws_q <= ws_d; br_q <= br_d; rr_q <= rr_d; rd_q <= rd_d;
            ctrl_q <= ctrl_d;
        end
    end

    assign s_axi_awready = ~awh_q & ~bv_q; assign s_axi_wready = ~wh_q & ~bv_q;
    assign s_axi_bvalid = bv_q; assign s_axi_bresp = br_q;
    assign s_axi_arready = ~rv_q; assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q; assign s_axi_rresp = rr_q;

    // Helper: cycles spent in residency, for the first-refresh bound
    logic [15:0] sr_cyc_q;
    logic        ref_seen_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || st_q != SRCTL_SR) begin
            sr_cyc_q <= 16'h0000; ref_seen_q <= 1'b0;
        end else begin
            sr_cyc_q <= sr_cyc_q + 16'h0001; ref_seen_q <= ref_seen_q | rp_q;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst || pin_rst);

    sequence exit_start_s;
        st_q == SRCTL_SR ##1 st_q == SRCTL_EXIT;
    endsequence

    sre_enter_a: assert property (st_q == SRCTL_IDLE && sre_cmd |=> sr_active)
        else $error("entry command not taken");
    term_off_a: assert property (sr_active |-> term_hiz && !int_clk_en)
        else $error("termination on in self refresh");
    park_back_a: assert property (exit_start_s |-> !term_hiz && term_park == (ctrl_q.park_en ? ctrl_q.parked_termination_value : 3'h0))
        else $error("parked termination not restored");
    dll_cycle_a: assert property (exit_start_s |-> dll_reset == ctrl_q.dll_on ##1 !dll_reset)
        else $error("dll reset pulse wrong at exit");
    pins_ignored_a: assert property (sr_active && !srx_cmd |=> sr_active)
        else $error("left self refresh without exit");
    vref_stable_a: assert property (fast_exit_ok && st_q == SRCTL_EXIT |-> vref_ready)
        else $error("reference not ready at exit delay");
    first_ref_a: assert property (sr_active && sr_cyc_q == 16'(FIRST_REF_CYC + 2) |-> ref_seen_q)
        else $error("no internal refresh in time");
    exit_seen_a: assert property (sr_active && srx_cmd |=> st_q == SRCTL_EXIT)
        else $error("exit not recognised");
    exit_delay_a: assert property ($rose(fast_exit_ok) |-> xcnt_q == xs_lim)
        else $error("exit delay count wrong");
    abort_cnt_a: assert property (abort_q |-> $stable(rcnt_q) && rbusy_q == 16'h0000)
        else $error("aborted refresh advanced counter");
    mode_rate_a: assert property (st_q == SRCTL_IDLE && ctrl_q.low_power_self_refresh_select != 2'b11
                                  ##1 st_q == SRCTL_IDLE |-> refresh_rate == $past(ctrl_q.low_power_self_refresh_select))
        else $error("refresh rate not following mode");
endmodule // srctl_top
